// >>> scrlm_regs.svh
`ifndef SCRLM_REGS_SVH
`define SCRLM_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define SCRLM_OFS_CMD 8'h00
`define SCRLM_OFS_STATUS 8'h04
`define SCRLM_OFS_IRQ_STAT 8'h08
`define SCRLM_OFS_IRQ_MASK 8'h0c
`define SCRLM_OFS_METER 8'h10

// ****************************************************************
// Command codes.
// ****************************************************************
`define SCRLM_CMD_ADDR_FREE 8'h09
`define SCRLM_CMD_ADDR_ONE 8'h89
`define SCRLM_CMD_PEAK 8'h2b
`define SCRLM_CMD_LEVEL 8'h2c
`define SCRLM_CMD_MASK_SET 8'h2d
`define SCRLM_CMD_MASK_CLR 8'h2e

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define SCRLM_ST_ADDR_FREE 0
`define SCRLM_ST_PEAK_MODE 1
`define SCRLM_ST_PEAK_MASK 2
`define SCRLM_ST_FROZEN 3
`define SCRLM_ST_READY 4
`define SCRLM_ST_LEFT 5
`define SCRLM_IRQ_Q_READY 0
`define SCRLM_IRQ_SUB_LATE 1
`define SCRLM_IRQ_PEAK_NEW 2
`define SCRLM_IRQ_TRK_DONE 3
`define SCRLM_IRQ_W 4
`define SCRLM_IRQ_MASK_RST 4'h0
`define SCRLM_Q_ADR_ONE 4'h1

// ****************************************************************
// Timing.
// ****************************************************************
`define SCRLM_CLK_PS 5000
`define SCRLM_SUB_WIN_PS 136000000
`define SCRLM_Q_HOLD_PS 64'd11200000000
`define SCRLM_SUB_WIN_CYC (`SCRLM_SUB_WIN_PS / `SCRLM_CLK_PS)
`define SCRLM_Q_HOLD_CYC (`SCRLM_Q_HOLD_PS / `SCRLM_CLK_PS)
`define SCRLM_SFS_HIGH_CYC 6'd32
`define SCRLM_Q_BITS 7'd96

`endif

// >>> scrlm_pkg.sv
package scrlm_pkg;

  typedef struct packed {
    logic valid;
    logic sync;
    logic [7:0] bits;
  } scrlm_sym_t;

  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic [79:0] data;
  } scrlm_qframe_t;

  typedef struct packed {
    logic valid;
    logic [15:0] left;
    logic [15:0] right;
  } scrlm_sample_t;

  typedef struct packed {
    logic active;
    logic half;
    logic done;
  } scrlm_track_t;

  typedef enum logic [1:0] {SCRLM_SC_IDLE, SCRLM_SC_STROBE, SCRLM_SC_READ} scrlm_sc_state_t;

endpackage

// >>> scrlm_top.sv
`timescale 1ns/1ps
`include "scrlm_regs.svh"
// Notes on behaviour
// - Host reads eight subcode bits within 136 us.
// - Subcode output changes on bit clock rises.
// - Without bit clock, output holds P bit.
// - Frame strobe per frame; fall presents P.
// - Block strobe high over sync; fall starts data.
// - Q ready needs CRC pass and address one; code 09 waives both.
// - Code 09 frees address; 89 restores, default.
// - Q clocking freezes holding; read pulse unfreezes.
// - Q ready drops alone after 11.2 ms.
// - Q bits go out LSB first, fixed order.
// - Q output driven only while select low.
// - Track count makes ready a progress monitor.
// - 2B peak mode, 2C level mode default.
// - Level word: channel flag, 15-bit magnitude.
// - Meter word follows 80 Q bits; 96 clocks.
// - Level readouts alternate channels, per-channel maxima.
// - Peak word zero top, readout leaves it.
// - Peak mode sends time latched after peak.
// - 2D masks peak growth, 2E unmasks, default.
module scrlm_top #(
  parameter int unsigned SUB_WIN_CYC = `SCRLM_SUB_WIN_CYC,
  parameter longint unsigned Q_HOLD_CYC = `SCRLM_Q_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire scrlm_pkg::scrlm_sym_t sym_in,
  input wire scrlm_pkg::scrlm_qframe_t q_in,
  input wire scrlm_pkg::scrlm_sample_t sample_in,
  input wire scrlm_pkg::scrlm_track_t track_in,
  input wire logic subcode_bit_clock,
  output logic subcode_serial_out,
  output logic subcode_frame_strobe,
  output logic subcode_block_strobe,
  input wire logic q_read_clock_n,
  input wire logic chip_select_n,
  input wire logic read_write_control,
  output logic q_serial_out,
  output logic q_serial_oe_n,
  output logic q_ready_flag
);
  import scrlm_pkg::*;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [3:0] pin_raw;
  logic [3:0] pin_m;
  logic [3:0] pin_s;
  logic [3:0] pin_d;
  assign pin_raw = {read_write_control, chip_select_n, q_read_clock_n, subcode_bit_clock};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Presets match each pin's idle level, so reset release shows no false edge.
      pin_m <= 4'h7;
      pin_s <= 4'h7;
      pin_d <= 4'h7;
    end
    else
    begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  wire subcode_bit_clock_rise = pin_s[0] & ~pin_d[0];
  wire q_read_clock_n_fall = ~pin_s[1] & pin_d[1];
  wire q_read_clock_n_rise = pin_s[1] & ~pin_d[1];
  wire cs_low = ~pin_s[2];
  wire cs_fall = ~pin_s[2] & pin_d[2];
  wire rwc_rise = pin_s[3] & ~pin_d[3];

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  logic addr_free;
  logic peak_mode;
  logic peak_mask;
  logic frozen;
  logic ready_int;
  logic chan_left;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [15:0] meter_word;

  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire sel_cmd = paddr == `SCRLM_OFS_CMD;
  wire sel_st = paddr == `SCRLM_OFS_STATUS;
  wire sel_is = paddr == `SCRLM_OFS_IRQ_STAT;
  wire sel_im = paddr == `SCRLM_OFS_IRQ_MASK;
  wire sel_mt = paddr == `SCRLM_OFS_METER;
  wire mapped = sel_cmd | sel_st | sel_is | sel_im | sel_mt;
  wire [7:0] cmd = pwdata[7:0];
  wire cmd_wr = wr & sel_cmd;
  wire [31:0] st_word = {26'h0, chan_left, ready_int, frozen, peak_mask, peak_mode, addr_free};
  wire [31:0] rd_word = sel_st ? st_word :
                        sel_is ? {28'h0, irq_stat} :
                        sel_im ? {28'h0, irq_mask} :
                        sel_mt ? {16'h0, meter_word} : 32'h0;

  // One wait state: the answer is built while pready is low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready)
      begin
        prdata <= pwrite ? 32'h0 : rd_word;
        pslverr <= ~mapped;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_free <= 1'b0;
      peak_mode <= 1'b0;
      peak_mask <= 1'b0;
    end
    else if (cmd_wr)
    begin
      if (cmd == `SCRLM_CMD_ADDR_FREE) addr_free <= 1'b1;
      if (cmd == `SCRLM_CMD_ADDR_ONE) addr_free <= 1'b0;
      if (cmd == `SCRLM_CMD_PEAK) peak_mode <= 1'b1;
      if (cmd == `SCRLM_CMD_LEVEL) peak_mode <= 1'b0;
      if (cmd == `SCRLM_CMD_MASK_SET) peak_mask <= 1'b1;
      if (cmd == `SCRLM_CMD_MASK_CLR) peak_mask <= 1'b0;
    end
  end

  // ****************************************************************
  // Subcode P to W stream.
  // ****************************************************************
  scrlm_sc_state_t sc_state;
  logic [5:0] sfs_cnt;
  logic [7:0] sub_shift;
  logic [7:0] sub_pend;
  logic [3:0] sub_bits;
  logic [31:0] win_cnt;
  logic sub_late;

  assign subcode_serial_out = sub_shift[7];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sc_state <= SCRLM_SC_IDLE;
      sfs_cnt <= 6'h0;
      sub_shift <= 8'h0;
      sub_pend <= 8'h0;
      sub_bits <= 4'h0;
      win_cnt <= 32'h0;
      sub_late <= 1'b0;
      subcode_frame_strobe <= 1'b0;
      subcode_block_strobe <= 1'b0;
    end
    else
    begin
      sub_late <= 1'b0;
      if (sym_in.valid)
      begin
        sc_state <= SCRLM_SC_STROBE;
        sfs_cnt <= `SCRLM_SFS_HIGH_CYC;
        sub_pend <= sym_in.bits;
        subcode_frame_strobe <= 1'b1;
        subcode_block_strobe <= sym_in.sync;
        sub_late <= sc_state == SCRLM_SC_READ && sub_bits < 4'd8;
      end
      else
      begin
        unique case (sc_state)
          SCRLM_SC_IDLE:
          begin
          end
          SCRLM_SC_STROBE:
          begin
            sfs_cnt <= sfs_cnt - 6'd1;
            if (sfs_cnt == 6'd1)
            begin
              subcode_frame_strobe <= 1'b0;
              sub_shift <= sub_pend;
              sub_bits <= 4'h0;
              win_cnt <= SUB_WIN_CYC;
              sc_state <= SCRLM_SC_READ;
            end
          end
          SCRLM_SC_READ:
          begin
            if (subcode_bit_clock_rise && sub_bits < 4'd8)
            begin
              sub_shift <= {sub_shift[6:0], 1'b0};
              sub_bits <= sub_bits + 4'd1;
            end
            if (win_cnt != 32'h0)
              win_cnt <= win_cnt - 32'd1;
            else
            begin
              sub_late <= sub_bits < 4'd8;
              sc_state <= SCRLM_SC_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Meters.
  // ****************************************************************
  function automatic logic [14:0] mag(input logic [15:0] s);
    logic [15:0] a;
    a = s[15] ? (16'h0 - s) : s;
    mag = a[15] ? 15'h7fff : a[14:0];
  endfunction

  logic [14:0] max_l;
  logic [14:0] max_r;
  logic [14:0] peak;
  logic peak_pend;
  logic peak_new;
  logic [23:0] peak_time;
  logic meter_done;

  wire [14:0] mag_l = mag(sample_in.left);
  wire [14:0] mag_r = mag(sample_in.right);
  wire [14:0] mag_max = mag_l > mag_r ? mag_l : mag_r;
  wire peak_up = sample_in.valid & ~peak_mask & (mag_max > peak);
  wire clr_l = meter_done & ~peak_mode & chan_left;
  wire clr_r = meter_done & ~peak_mode & ~chan_left;
  wire [14:0] base_l = clr_l ? 15'h0 : max_l;
  wire [14:0] base_r = clr_r ? 15'h0 : max_r;

  assign meter_word = peak_mode ? {1'b0, peak} :
                      {chan_left, chan_left ? max_l : max_r};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      max_l <= 15'h0;
      max_r <= 15'h0;
      peak <= 15'h0;
      peak_pend <= 1'b0;
      peak_new <= 1'b0;
      peak_time <= 24'h0;
      chan_left <= 1'b1;
    end
    else
    begin
      // A sample arriving on the clearing cycle still counts.
      max_l <= (sample_in.valid && mag_l > base_l) ? mag_l : base_l;
      max_r <= (sample_in.valid && mag_r > base_r) ? mag_r : base_r;
      if (meter_done && !peak_mode)
        chan_left <= ~chan_left;
      if (peak_up)
        peak <= mag_max;
      peak_new <= peak_up;
      if (peak_up)
        peak_pend <= 1'b1;
      else if (q_in.valid && peak_pend)
      begin
        peak_time <= q_in.data[79:56];
        peak_pend <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Subcode Q holding register and serial port.
  // ****************************************************************
  logic [79:0] q_hold;
  logic [95:0] q_shift;
  logic [6:0] q_bits;
  logic [31:0] hold_cnt;
  logic trk_flag;
  logic trk_done_ev;

  wire q_ok = addr_free | (q_in.crc_ok & (q_in.data[3:0] == `SCRLM_Q_ADR_ONE));
  wire q_take = q_in.valid & ~frozen & q_ok;
  wire [79:0] q_view = peak_mode ? {peak_time, q_hold[55:0]} : q_hold;
  wire [6:0] q_bits_inc = q_bits + 7'd1;
  assign q_serial_out = q_shift[0];
  assign meter_done = q_read_clock_n_rise & cs_low & (q_bits_inc == `SCRLM_Q_BITS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_hold <= 80'h0;
      frozen <= 1'b0;
      ready_int <= 1'b0;
      hold_cnt <= 32'h0;
    end
    else
    begin
      if (q_take)
        q_hold <= q_in.data;
      if (cs_low && q_read_clock_n_fall)
        frozen <= 1'b1;
      else if (rwc_rise)
        frozen <= 1'b0;
      if (q_take)
      begin
        ready_int <= 1'b1;
        hold_cnt <= 32'(Q_HOLD_CYC);
      end
      else if (rwc_rise)
        ready_int <= 1'b0;
      else if (ready_int)
      begin
        hold_cnt <= hold_cnt - 32'd1;
        if (hold_cnt == 32'd1)
          ready_int <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_shift <= 96'h0;
      q_bits <= 7'h0;
      q_serial_oe_n <= 1'b1;
    end
    else
    begin
      q_serial_oe_n <= ~cs_low;
      if (cs_fall)
      begin
        q_shift <= {meter_word, q_view};
        q_bits <= 7'h0;
      end
      else if (cs_low && q_read_clock_n_rise && q_bits != `SCRLM_Q_BITS)
      begin
        q_shift <= {1'b0, q_shift[95:1]};
        q_bits <= q_bits_inc;
      end
    end
  end

  // ****************************************************************
  // Ready pin, track progress and interrupts.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trk_flag <= 1'b0;
      trk_done_ev <= 1'b0;
      q_ready_flag <= 1'b0;
      irq_stat <= 4'h0;
      irq_mask <= `SCRLM_IRQ_MASK_RST;
      irq <= 1'b0;
    end
    else
    begin
      if (track_in.half)
        trk_flag <= 1'b1;
      else if (track_in.done)
        trk_flag <= 1'b0;
      trk_done_ev <= track_in.done;
      q_ready_flag <= track_in.active ? trk_flag : ready_int;
      if (wr && sel_im)
        irq_mask <= pwdata[3:0];
      // New events win over a write-one clear in the same cycle.
      irq_stat <= (irq_stat & ~((wr && sel_is) ? pwdata[3:0] : 4'h0)) |
                  {trk_done_ev, peak_new, sub_late, q_take};
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sub_on_rise: assert property (!$stable(sub_shift) |->
      $past(sym_in.valid) || $past(sc_state) == SCRLM_SC_STROBE || $past(subcode_bit_clock_rise))
    else $error("subcode output moved without a bit clock rise");
  a_sub_hold_p: assert property ($fell(subcode_frame_strobe) |->
      subcode_serial_out == $past(sub_pend[7]))
    else $error("P bit not presented at frame strobe fall");
  a_block_sync: assert property ($past(sym_in.valid) |->
      subcode_block_strobe == $past(sym_in.sync))
    else $error("block strobe does not follow sync symbols");
  a_q_take_ok: assert property ($rose(ready_int) |->
      $past(addr_free) || ($past(q_in.crc_ok) && $past(q_in.data[3:0]) == 4'h1))
    else $error("Q ready raised for bad frame");
  a_addr_cmd: assert property (cmd_wr && cmd == `SCRLM_CMD_ADDR_FREE |=> addr_free)
    else $error("address free command ignored");
  a_freeze_read: assert property (cs_low && q_read_clock_n_fall |=> frozen ##0 !q_take)
    else $error("holding register not frozen on Q clock");
  a_rwc_drop: assert property (rwc_rise && !q_take |=> !ready_int && !frozen)
    else $error("read complete did not drop ready");
  a_ready_time: assert property ($rose(ready_int) |->
      hold_cnt == 32'(Q_HOLD_CYC))
    else $error("ready hold count out of range");
  a_oe_select: assert property (q_serial_oe_n == $past(~cs_low))
    else $error("Q output enable does not track select");
  a_track_mon: assert property (track_in.active && track_in.half ##1 track_in.active
      |=> q_ready_flag)
    else $error("track progress not shown on ready");
  a_peak_word: assert property (peak_mode |-> meter_word[15] == 1'b0)
    else $error("peak word top bit set");
  a_peak_mask: assert property (peak_mask |=> $stable(peak))
    else $error("masked peak changed");
  a_lvm_toggle: assert property (meter_done && !peak_mode |=> chan_left != $past(chan_left))
    else $error("level channel did not alternate");

  c_q_read: cover property ($rose(ready_int) ##[1:1000] meter_done);
  c_sub_frame: cover property ($fell(subcode_frame_strobe) ##[1:1000] subcode_bit_clock_rise);
  c_peak_up: cover property (peak_mode && peak_up);
  c_track: cover property (track_in.active && $fell(q_ready_flag));

endmodule

// >>> scrlm_host_model.sv
`timescale 1ns/1ps
module scrlm_host_model (
  output logic subcode_bit_clock,
  output logic q_read_clock_n,
  output logic chip_select_n,
  output logic read_write_control,
  input wire logic subcode_serial_out,
  input wire logic q_serial_out,
  input wire logic q_serial_oe_n
);
  // ********
  // Host reads over the serial pins.
  // ********
  // Both clocks stand still high between reads, so no edge is seen outside a transfer.
  initial
  begin
    {subcode_bit_clock, q_read_clock_n, chip_select_n} = 3'b111;
    read_write_control = 1'b0;
  end
  // Each bit is taken just after the fall and again before the rise; the two differ
  // only if the output moved on the wrong edge.
  task automatic read_sub(input int n, output logic [7:0] early, output logic [7:0] late);
    early = 8'h00;
    late = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      subcode_bit_clock = 1'b0;
      #4;
      early[7 - i] = subcode_serial_out;
      #28;
      late[7 - i] = subcode_serial_out;
      subcode_bit_clock = 1'b1;
      #32;
    end
  endtask
  task automatic read_q(output logic [95:0] word, output logic [1:0] oe);
    chip_select_n = 1'b0;
    #64;
    oe[0] = q_serial_oe_n;
    for (int i = 0; i < 96; i++)
    begin
      q_read_clock_n = 1'b0;
      #32;
      word[i] = q_serial_out;
      q_read_clock_n = 1'b1;
      #32;
    end
    chip_select_n = 1'b1;
    #64;
    oe[1] = q_serial_oe_n;
  endtask
  task automatic finish_q;
    read_write_control = 1'b1;
    #64;
    read_write_control = 1'b0;
    #64;
  endtask
endmodule

// >>> test_scrlm_top.sv
`timescale 1ns/1ps
`include "scrlm_regs.svh"
module test_scrlm_top;
  import scrlm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic subcode_bit_clock, subcode_serial_out, subcode_frame_strobe, subcode_block_strobe;
  logic q_read_clock_n, chip_select_n, read_write_control, q_serial_out, q_serial_oe_n;
  logic q_ready_flag, rd_err;
  scrlm_sym_t sym_in;
  scrlm_qframe_t q_in;
  scrlm_sample_t sample_in;
  scrlm_track_t track_in;
  int bad_count, checks_done;
  logic [7:0] e, l;
  logic [95:0] w;
  logic [1:0] oe;
  logic [7:0] codes [6] = '{8'h09, 8'h89, 8'h2b, 8'h2c, 8'h2d, 8'h2e};
  logic [31:0] stat [6] = '{32'h21, 32'h20, 32'h22, 32'h20, 32'h24, 32'h20};
  localparam logic [79:0] D1 = 80'h0102_0304_0506_0708_0911;
  localparam logic [79:0] D2 = 80'h2122_2324_2526_2728_2931;
  localparam logic [79:0] DA = 80'h1122_3300_0000_0000_0001;
  localparam logic [79:0] DB = 80'h4455_6600_0000_0000_0001;
  // Short counts keep the run brief; the late-subcode and ready-timeout expectations below follow from them.
  scrlm_top #(.SUB_WIN_CYC(200), .Q_HOLD_CYC(2000)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .sym_in, .q_in, .sample_in, .track_in, .subcode_bit_clock,
    .subcode_serial_out, .subcode_frame_strobe, .subcode_block_strobe, .q_read_clock_n,
    .chip_select_n, .read_write_control, .q_serial_out, .q_serial_oe_n, .q_ready_flag);
  scrlm_host_model host (
    .subcode_bit_clock, .q_read_clock_n, .chip_select_n, .read_write_control,
    .subcode_serial_out, .q_serial_out, .q_serial_oe_n);
  // ********
  // Shared tasks.
  // ********
  task automatic check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      close_out;
    end
    rd_data = prdata;
    rd_err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd_data, x);
  endtask
  task automatic sym(input logic s, input logic [7:0] b);
    @(posedge pclk);
    sym_in <= '{1'b1, s, b};
    @(posedge pclk);
    sym_in.valid <= 1'b0;
  endtask
  task automatic qf(input logic c, input logic [79:0] d);
    @(posedge pclk);
    q_in <= '{1'b1, c, d};
    @(posedge pclk);
    q_in.valid <= 1'b0;
  endtask
  task automatic smp(input logic [15:0] lf, input logic [15:0] rt);
    @(posedge pclk);
    sample_in <= '{1'b1, lf, rt};
    @(posedge pclk);
    sample_in.valid <= 1'b0;
  endtask
  task automatic trk(input logic h, input logic d);
    @(posedge pclk);
    track_in <= '{1'b1, h, d};
    @(posedge pclk);
    track_in <= '{1'b1, 1'b0, 1'b0};
  endtask
  task automatic wfall;
    int n;
    for (n = 0; n < 100 && subcode_frame_strobe !== 1'b0; n++)
      @(posedge pclk);
    check("strobe fall", n < 100, 1'b1);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ********
  // Main sequence.
  // ********
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sym_in, q_in, sample_in, track_in} = '0;
    bad_count = 0;
    checks_done = 0;
    cyc(16);
    presetn <= 1'b1;
    rd(`SCRLM_OFS_STATUS, 32'h20, "status reset");
    rd(`SCRLM_OFS_IRQ_MASK, 32'h0, "mask reset");
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped err", rd_err, 1'b1);
    check("unmapped data", rd_data, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(`SCRLM_OFS_CMD, codes[i]);
      rd(`SCRLM_OFS_STATUS, stat[i], "command status");
    end
    $display("test commands done");
    wr(`SCRLM_OFS_IRQ_MASK, 32'h2);
    sym(1'b1, 8'ha5);
    cyc(2);
    check("frame strobe", subcode_frame_strobe, 1'b1);
    check("block strobe", subcode_block_strobe, 1'b1);
    wfall;
    check("p at fall", subcode_serial_out, 1'b1);
    cyc(40);
    check("p held", subcode_serial_out, 1'b1);
    host.read_sub(8, e, l);
    check("bits early", e, 8'ha5);
    check("bits late", l, 8'ha5);
    cyc(250);
    check("no late irq", irq, 1'b0);
    sym(1'b0, 8'h3c);
    cyc(2);
    check("block strobe low", subcode_block_strobe, 1'b0);
    wfall;
    host.read_sub(4, e, l);
    cyc(250);
    check("late irq", irq, 1'b1);
    rd(`SCRLM_OFS_IRQ_STAT, 32'h2, "late stat");
    wr(`SCRLM_OFS_IRQ_STAT, 32'h2);
    cyc(3);
    check("irq cleared", irq, 1'b0);
    $display("test subcode done");
    wr(`SCRLM_OFS_IRQ_MASK, 32'h1);
    smp(16'h0123, 16'hfbaa);
    qf(1'b0, D2);
    qf(1'b1, {D2[79:8], 8'h32});
    cyc(2);
    check("ready refused", q_ready_flag, 1'b0);
    qf(1'b1, D1);
    cyc(3);
    check("ready", q_ready_flag, 1'b1);
    check("ready irq", irq, 1'b1);
    host.read_q(w, oe);
    check("q word", w, {16'h8123, D1});
    check("q enable", oe, 2'b10);
    rd(`SCRLM_OFS_STATUS, 32'h18, "frozen");
    qf(1'b1, D2);
    host.finish_q;
    cyc(2);
    check("ready drop", q_ready_flag, 1'b0);
    host.read_q(w, oe);
    host.finish_q;
    check("q hold kept", w, {16'h0456, D1});
    wr(`SCRLM_OFS_CMD, 32'h09);
    qf(1'b0, {D2[79:8], 8'h32});
    cyc(2);
    check("address free", q_ready_flag, 1'b1);
    host.finish_q;
    wr(`SCRLM_OFS_CMD, 32'h89);
    qf(1'b1, D2);
    cyc(1990);
    check("ready held", q_ready_flag, 1'b1);
    cyc(20);
    check("ready timeout", q_ready_flag, 1'b0);
    trk(1'b1, 1'b0);
    cyc(2);
    check("track half", q_ready_flag, 1'b1);
    trk(1'b0, 1'b1);
    cyc(2);
    check("track done", q_ready_flag, 1'b0);
    track_in <= '0;
    apb(1'b0, `SCRLM_OFS_IRQ_STAT, 32'h0);
    check("track stat", rd_data[3], 1'b1);
    $display("test q port done");
    wr(`SCRLM_OFS_CMD, 32'h2b);
    smp(16'h3000, 16'h0000);
    rd(`SCRLM_OFS_METER, 32'h3000, "peak");
    qf(1'b1, DA);
    qf(1'b1, DB);
    host.read_q(w, oe);
    host.finish_q;
    check("peak time", w, {16'h3000, DA[79:56], DB[55:0]});
    rd(`SCRLM_OFS_METER, 32'h3000, "peak kept");
    wr(`SCRLM_OFS_CMD, 32'h2d);
    smp(16'h3500, 16'h0000);
    rd(`SCRLM_OFS_METER, 32'h3000, "peak masked");
    wr(`SCRLM_OFS_CMD, 32'h2e);
    smp(16'h0000, 16'hcb00);
    rd(`SCRLM_OFS_METER, 32'h3500, "peak right");
    $display("test peak done");
    close_out;
  end
endmodule
